// file: src/fsf_feature_table.sv
/*
  Feature table of a serial flash with its directly acting commands:
  software reset, write latch set/clear, feature write and feature read.
  Assumes a serial host in clock mode 0 (sample on rising link clock,
  shift on falling), link clock well below a quarter of the core clock,
  and an array core on the same clock that reports its status and
  takes the accepted program, protect and erase commands.
*/
`timescale 1ns/100ps

// Summary of operation
// - both reset opcodes do the same reset
// - reset aborts program/erase, busy until discharged
// - write enable sets the write latch
// - write disable clears the write latch
// - latch clear: program, protect, erase ignored
// - feature write and read, one byte address
// - software reset keeps written feature values
// - feature write never touches the write latch
// - reserved bits read as zero
// - ecc bits meaningful only with ecc on
// - power-on reset loads all defaults
// - guard plus pin low blocks lock writes
// - lock range decodes none, fractions, all
// - protect arm defaults zero, gates protect opcode
// - id read select defaults zero
// - ecc switch writable, default one
// - bad block guard read only, one
// - fast read enable writable, default one
// - status bit 0 shows busy
// - feature read repeats byte until deselect
// - busy and fail flags update live
module fsf_feature_table (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    link_sck,
  input  wire logic                    cs_n,
  input  wire logic                    si,
  input  wire logic                    wp_n,
  output logic                         so_o,
  output logic                         so_oe,
  input  wire fsf_pkg::fsf_core_stat_t core_stat,
  output fsf_pkg::fsf_cmd_t            cmd_o,
  output logic                         abort_o,
  output logic                         protect_arm_o,
  output logic                         id_read_select_o,
  output logic                         ecc_enable_o,
  output logic                         fast_read_enable_o,
  output logic [3:0]                   flip_threshold_o
);

  // ************************************************************
  // declarations
  // ************************************************************
  typedef enum logic [2:0] {ST_OPCODE, ST_ADDR, ST_DATA, ST_ROW, ST_READ, ST_DONE} fsf_state_t;

  logic [3:0]  pin_s;
  logic        sck_s;
  logic        cs_n_s;
  logic        si_s;
  logic        wp_n_s;
  logic        sck_d_r;
  logic        cs_d_r;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;
  fsf_state_t  state_r;
  logic [4:0]  bitcnt_r;
  logic [23:0] shift_r;
  logic [23:0] shift_nxt;
  logic [7:0]  opcode_r;
  logic [7:0]  addr_r;
  logic [7:0]  wdata_r;
  logic [fsf_pkg::ROW_BITS-1:0] row_r;
  logic        frame_ok_r;
  logic        exec;
  logic [7:0]  lock_r;
  logic [7:0]  cfg_r;
  logic [7:0]  thresh_r;
  logic        wel_r;
  logic [15:0] rst_cnt_r;
  logic        busy;
  logic        ecc_on;
  logic        row_locked;
  logic [2:0]  rbit_r;
  logic [6:0]  out_byte_r;
  logic [7:0]  rd_byte;
  logic        so_r;
  logic        so_oe_r;
  logic        abort_r;
  fsf_pkg::fsf_cmd_t cmd_r;

  // ************************************************************
  // decode helpers
  // ************************************************************
  // both reset opcodes map to one operation
  function automatic logic is_reset(input logic [7:0] op);
    return (op == fsf_pkg::OP_RESET_A) || (op == fsf_pkg::OP_RESET_B);
  endfunction

  // opcodes that carry a three-byte row address
  function automatic logic is_row_op(input logic [7:0] op);
    return (op == fsf_pkg::OP_PROG_EXEC) || (op == fsf_pkg::OP_PROT_EXEC) ||
           (op == fsf_pkg::OP_ERASE);
  endfunction

  // ************************************************************
  // pin synchronisers and edge detection
  // ************************************************************
  fsf_sync #(
    .W       (4),
    .RST_VAL (4'b1010)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({cs_n, link_sck, wp_n, si}),
    .q     (pin_s)
  );

  assign cs_n_s = pin_s[3];
  assign sck_s  = pin_s[2];
  assign wp_n_s = pin_s[1];
  assign si_s   = pin_s[0];

  // previous synchronised levels for edge finding
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r  <= cs_n_s;
    end
  end

  // edges only count inside a frame; a stray clock while idle is ignored
  assign sck_rise  = ~cs_n_s & sck_s & ~sck_d_r;
  assign sck_fall  = ~cs_n_s & ~sck_s & sck_d_r;
  assign cs_rise   = cs_n_s & ~cs_d_r;
  assign shift_nxt = {shift_r[22:0], si_s};  // msb first

  // ************************************************************
  // status
  // ************************************************************
  // busy covers array work and the reset discharge time
  assign busy   = core_stat.busy | (rst_cnt_r != 16'h0000);
  assign ecc_on = cfg_r[fsf_pkg::CFG_ECC_BIT];
  // a frame acts on its deselect, and only when complete
  assign exec   = cs_rise & frame_ok_r;

  // ************************************************************
  // frame state machine
  // ************************************************************
  // collects opcode, address, data or row bits one rising edge at a time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r    <= ST_OPCODE;
      bitcnt_r   <= 5'd0;
      shift_r    <= 24'h00_0000;
      opcode_r   <= 8'h00;
      addr_r     <= 8'h00;
      wdata_r    <= 8'h00;
      row_r      <= '0;
      frame_ok_r <= 1'b0;
    end else if (cs_n_s) begin
      state_r    <= ST_OPCODE;
      bitcnt_r   <= 5'd0;
      frame_ok_r <= 1'b0;
    end else if (sck_rise) begin
      shift_r  <= shift_nxt;
      bitcnt_r <= bitcnt_r + 5'd1;
      unique case (state_r)
        ST_OPCODE: begin
          if (bitcnt_r == 5'd7) begin
            opcode_r <= shift_nxt[7:0];
            bitcnt_r <= 5'd0;
            if (busy && !is_reset(shift_nxt[7:0]) && shift_nxt[7:0] != fsf_pkg::OP_FEAT_READ) begin
              state_r <= ST_DONE;  // opcode refused while busy
            end else if (shift_nxt[7:0] == fsf_pkg::OP_FEAT_READ ||
                         shift_nxt[7:0] == fsf_pkg::OP_FEAT_WRITE) begin
              state_r <= ST_ADDR;
            end else if (is_row_op(shift_nxt[7:0])) begin
              state_r <= ST_ROW;
            end else begin
              state_r    <= ST_DONE;
              frame_ok_r <= 1'b1;
            end
          end
        end
        ST_ADDR: begin
          if (bitcnt_r == 5'd7) begin
            addr_r   <= shift_nxt[7:0];
            bitcnt_r <= 5'd0;
            state_r  <= (opcode_r == fsf_pkg::OP_FEAT_READ) ? ST_READ : ST_DATA;
          end
        end
        ST_DATA: begin
          if (bitcnt_r == 5'd7) begin
            wdata_r    <= shift_nxt[7:0];
            frame_ok_r <= 1'b1;  // full three-byte frame
            state_r    <= ST_DONE;
          end
        end
        ST_ROW: begin
          if (bitcnt_r == 5'd23) begin
            row_r      <= shift_nxt[fsf_pkg::ROW_BITS-1:0];
            frame_ok_r <= 1'b1;
            state_r    <= ST_DONE;
          end
        end
        ST_READ: begin
          bitcnt_r <= 5'd0;  // host bits ignored while streaming
        end
        ST_DONE: begin
          bitcnt_r <= 5'd0;
        end
      endcase
    end
  end

  // ************************************************************
  // writable feature bytes
  // ************************************************************
  // only the power-on reset restores defaults; the software reset
  // opcode does not reach these flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lock_r   <= fsf_pkg::LOCK_RST;
      cfg_r    <= fsf_pkg::CFG_RST;
      thresh_r <= fsf_pkg::THRESH_RST;
    end else if (exec && opcode_r == fsf_pkg::OP_FEAT_WRITE) begin
      unique case (addr_r)
        fsf_pkg::ADDR_BLOCK_LOCK: begin
          // guard set and pin low freezes guard and range together
          if (!(lock_r[fsf_pkg::LOCK_GUARD_BIT] && !wp_n_s)) begin
            lock_r <= wdata_r & fsf_pkg::LOCK_WMASK;
          end
        end
        fsf_pkg::ADDR_FEAT_CFG: begin
          cfg_r <= wdata_r & fsf_pkg::CFG_WMASK;
        end
        fsf_pkg::ADDR_FLIP_THRESH: begin
          thresh_r <= wdata_r & fsf_pkg::THRESH_WMASK;
        end
        default: begin
          // read-only, status and undefined addresses store nothing
        end
      endcase
    end
  end

  // ************************************************************
  // write latch
  // ************************************************************
  // only the two latch opcodes move it; feature writes never do
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wel_r <= 1'b0;
    end else if (exec && opcode_r == fsf_pkg::OP_WRITE_EN) begin
      wel_r <= 1'b1;
    end else if (exec && opcode_r == fsf_pkg::OP_WRITE_DIS) begin
      wel_r <= 1'b0;
    end
  end

  // ************************************************************
  // software reset and abort
  // ************************************************************
  // an abort goes to the core only if it is actually busy; busy then
  // stays up for the discharge time so the host polls until ready
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rst_cnt_r <= 16'h0000;
      abort_r   <= 1'b0;
    end else if (exec && is_reset(opcode_r)) begin
      rst_cnt_r <= fsf_pkg::RESET_BUSY_CYC;
      abort_r   <= core_stat.busy;
    end else begin
      abort_r <= 1'b0;
      if (rst_cnt_r != 16'h0000) begin
        rst_cnt_r <= rst_cnt_r - 16'h0001;
      end
    end
  end

  // ************************************************************
  // array command issue
  // ************************************************************
  fsf_lock_decode u_lock (
    .range  (lock_r[fsf_pkg::LOCK_RANGE_LSB +: 3]),
    .block  (row_r[fsf_pkg::ROW_BITS-1:fsf_pkg::PAGE_BITS]),
    .locked (row_locked)
  );

  // a one-cycle pulse per accepted command; the locked flag lets the
  // core fail the operation instead of touching the array
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_r <= '0;
    end else begin
      cmd_r.valid  <= 1'b0;
      cmd_r.row    <= row_r;
      cmd_r.locked <= row_locked;
      if (exec && is_row_op(opcode_r) && wel_r && !busy) begin
        if (opcode_r == fsf_pkg::OP_PROG_EXEC) begin
          cmd_r.valid <= 1'b1;
          cmd_r.kind  <= fsf_pkg::CMD_PROGRAM;
        end else if (opcode_r == fsf_pkg::OP_ERASE) begin
          cmd_r.valid <= 1'b1;
          cmd_r.kind  <= fsf_pkg::CMD_ERASE;
        end else if (cfg_r[fsf_pkg::CFG_PROTECT_BIT]) begin
          cmd_r.valid <= 1'b1;
          cmd_r.kind  <= fsf_pkg::CMD_PROTECT;
        end
      end
    end
  end

  // ************************************************************
  // feature read data
  // ************************************************************
  // live view of the addressed byte; ecc fields read zero with ecc off
  always_comb begin
    rd_byte = 8'h00;  // reserved and undefined read zero
    unique case (addr_r)
      fsf_pkg::ADDR_BLOCK_LOCK:  rd_byte = lock_r;
      fsf_pkg::ADDR_FEAT_CFG:    rd_byte = cfg_r | fsf_pkg::CFG_RO_ONES;
      fsf_pkg::ADDR_OP_STATUS:   rd_byte = {2'b00, ecc_on ? core_stat.ecc_result : 2'b00,
                                            core_stat.prog_fail, core_stat.erase_fail,
                                            wel_r, busy};
      fsf_pkg::ADDR_FLIP_THRESH: rd_byte = thresh_r;
      fsf_pkg::ADDR_FLIP_SECTOR: rd_byte = ecc_on ? core_stat.sector_flags : 8'h00;
      fsf_pkg::ADDR_MAX_FLIP:    rd_byte = ecc_on ? (core_stat.max_report & fsf_pkg::MAX_FLIP_MASK)
                                                  : 8'h00;
      fsf_pkg::ADDR_FLIP_RPT0:   rd_byte = ecc_on ? core_stat.flip_report[7:0] : 8'h00;
      fsf_pkg::ADDR_FLIP_RPT1:   rd_byte = ecc_on ? core_stat.flip_report[15:8] : 8'h00;
      fsf_pkg::ADDR_FLIP_RPT2:   rd_byte = ecc_on ? core_stat.flip_report[23:16] : 8'h00;
      fsf_pkg::ADDR_FLIP_RPT3:   rd_byte = ecc_on ? core_stat.flip_report[31:24] : 8'h00;
      default:                   rd_byte = 8'h00;
    endcase
  end

  // ************************************************************
  // serial output shifter
  // ************************************************************
  // reloads at every byte boundary, so status flags are fresh on each
  // repetition; streams until the host deselects
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rbit_r     <= 3'd0;
      out_byte_r <= 7'h00;
      so_r       <= 1'b0;
      so_oe_r    <= 1'b0;
    end else begin
      so_oe_r <= ~cs_n_s && (state_r == ST_READ);
      if (state_r != ST_READ || cs_n_s) begin
        rbit_r <= 3'd0;
        so_r   <= 1'b0;
      end else if (sck_fall) begin
        rbit_r <= rbit_r + 3'd1;  // wraps to repeat the byte
        if (rbit_r == 3'd0) begin
          so_r       <= rd_byte[7];
          out_byte_r <= rd_byte[6:0];
        end else begin
          so_r       <= out_byte_r[6];
          out_byte_r <= {out_byte_r[5:0], 1'b0};
        end
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign so_o               = so_r;
  assign so_oe              = so_oe_r;
  assign cmd_o              = cmd_r;
  assign abort_o            = abort_r;
  assign protect_arm_o      = cfg_r[fsf_pkg::CFG_PROTECT_BIT];
  assign id_read_select_o   = cfg_r[fsf_pkg::CFG_ID_READ_BIT];
  assign ecc_enable_o       = cfg_r[fsf_pkg::CFG_ECC_BIT];
  assign fast_read_enable_o = cfg_r[fsf_pkg::CFG_FAST_BIT];
  assign flip_threshold_o   = thresh_r[fsf_pkg::THRESH_LSB +: 4];

endmodule

// file: src/fsf_pkg.sv
/*
  Package for the serial flash feature table: opcodes, table addresses,
  field positions, masks, reset values, timing counts and the carrier types.
  Assumes a single 100 MHz core clock; no other files are needed.
*/
package fsf_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_MHZ            = 100;
  // busy time after a software reset, in ns
  localparam int RESET_BUSY_NS      = 5000;
  // least time, so rounded up to whole cycles
  localparam logic [15:0] RESET_BUSY_CYC =
    16'((RESET_BUSY_NS * CLK_MHZ + 999) / 1000);

  // ************************************************************
  // opcodes
  // ************************************************************
  localparam logic [7:0] OP_RESET_A    = 8'hFF;
  localparam logic [7:0] OP_RESET_B    = 8'hFE;
  localparam logic [7:0] OP_WRITE_EN   = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS  = 8'h04;
  localparam logic [7:0] OP_FEAT_WRITE = 8'h1F;
  localparam logic [7:0] OP_FEAT_READ  = 8'h0F;
  localparam logic [7:0] OP_PROG_EXEC  = 8'h10;
  localparam logic [7:0] OP_PROT_EXEC  = 8'h2A;
  localparam logic [7:0] OP_ERASE      = 8'hD8;

  // ************************************************************
  // feature table addresses
  // ************************************************************
  localparam logic [7:0] ADDR_FLIP_THRESH = 8'h10;
  localparam logic [7:0] ADDR_FLIP_SECTOR = 8'h20;
  localparam logic [7:0] ADDR_MAX_FLIP    = 8'h30;
  localparam logic [7:0] ADDR_FLIP_RPT0   = 8'h40;
  localparam logic [7:0] ADDR_FLIP_RPT1   = 8'h50;
  localparam logic [7:0] ADDR_FLIP_RPT2   = 8'h60;
  localparam logic [7:0] ADDR_FLIP_RPT3   = 8'h70;
  localparam logic [7:0] ADDR_BLOCK_LOCK  = 8'hA0;
  localparam logic [7:0] ADDR_FEAT_CFG    = 8'hB0;
  localparam logic [7:0] ADDR_OP_STATUS   = 8'hC0;

  // ************************************************************
  // field positions, masks and reset values
  // ************************************************************
  localparam int LOCK_GUARD_BIT   = 7;
  localparam int LOCK_RANGE_LSB   = 3;
  localparam int CFG_PROTECT_BIT  = 7;
  localparam int CFG_ID_READ_BIT  = 6;
  localparam int CFG_ECC_BIT      = 4;
  localparam int CFG_FAST_BIT     = 1;
  localparam int THRESH_LSB       = 4;
  localparam logic [7:0] LOCK_WMASK    = 8'hB8;
  localparam logic [7:0] CFG_WMASK     = 8'hD2;
  localparam logic [7:0] CFG_RO_ONES   = 8'h04;
  localparam logic [7:0] THRESH_WMASK  = 8'hF0;
  localparam logic [7:0] MAX_FLIP_MASK = 8'hF7;
  localparam logic [7:0] LOCK_RST      = 8'h38;
  localparam logic [7:0] CFG_RST       = 8'h12;
  localparam logic [7:0] THRESH_RST    = 8'h00;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int ROW_BITS   = 17;
  localparam int PAGE_BITS  = 6;
  localparam int BLOCK_BITS = 11;

  // ************************************************************
  // carrier types
  // ************************************************************
  typedef struct packed {
    logic        busy;
    logic        prog_fail;
    logic        erase_fail;
    logic [1:0]  ecc_result;
    logic [7:0]  sector_flags;
    logic [7:0]  max_report;
    logic [31:0] flip_report;
  } fsf_core_stat_t;

  typedef enum logic [1:0] {CMD_PROGRAM, CMD_PROTECT, CMD_ERASE} fsf_cmd_kind_t;

  typedef struct packed {
    logic                valid;
    fsf_cmd_kind_t       kind;
    logic [ROW_BITS-1:0] row;
    logic                locked;
  } fsf_cmd_t;

endpackage

// file: src/fsf_sync.sv
/*
  Two-flop synchroniser for pins that arrive from outside the core clock.
  Assumes each bit is an independent level; the reset value is a constant.
*/
`timescale 1ns/100ps
module fsf_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ************************************************************
  // synchroniser stages
  // ************************************************************
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// file: src/fsf_lock_decode.sv
/*
  Decoder from the 3-bit lock range and a block index to a locked flag.
  Assumes 2048 blocks; purely combinational, the caller registers it.
*/
`timescale 1ns/100ps
module fsf_lock_decode (
  input  wire logic [2:0]                     range,
  input  wire logic [fsf_pkg::BLOCK_BITS-1:0] block,
  output logic                                locked
);

  // ************************************************************
  // range decode
  // ************************************************************
  // range r in 1..6 locks the top 2^(r-7) share: index bits from 4+r up
  // must all be one; 7 needs none of them, 0 locks nothing
  always_comb begin
    locked = (range != 3'd0);
    for (int i = 0; i < fsf_pkg::BLOCK_BITS; i++) begin
      if ((i >= 4 + int'(range)) && !block[i]) begin
        locked = 1'b0;
      end
    end
  end

endmodule

// file: dv/fsf_feature_table_checker.sv
/* Port assertions for fsf_feature_table.
   Assumes a bind from the bench and one clock domain. */
`timescale 1ns/100ps
module fsf_feature_table_checker (
  input wire logic                    clock,
  input wire logic                    rst,
  input wire logic                    cs_n,
  input wire logic                    so_oe,
  input wire fsf_pkg::fsf_core_stat_t core_stat,
  input wire fsf_pkg::fsf_cmd_t       cmd_o,
  input wire logic                    abort_o,
  input wire logic                    protect_arm_o,
  input wire logic                    ecc_enable_o,
  input wire logic                    fast_read_enable_o,
  input wire logic [3:0]              flip_threshold_o
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // ****
  // frame ends and pulse shapes
  // ****
  // select long high: read phase must be over
  sequence s_desel;
    cs_n [*6];
  endsequence
  // effects only land once select has risen
  sequence s_after_cs;
    $past(cs_n, 2) && cs_n;
  endsequence
  a_abort_one: assert property (abort_o |=> !abort_o)
    else $error("abort pulse too long");
  a_abort_busy: assert property (abort_o |-> cs_n && $past(core_stat.busy))
    else $error("abort without busy core");
  a_cmd_one: assert property (cmd_o.valid |=> !cmd_o.valid)
    else $error("command pulse too long");
  a_cmd_end: assert property (cmd_o.valid |-> s_after_cs)
    else $error("command before frame end");
  a_cfg_end: assert property ($changed({protect_arm_o, ecc_enable_o,
    fast_read_enable_o}) |-> s_after_cs)
    else $error("config moved inside frame");
  a_thr_end: assert property ($changed(flip_threshold_o) |-> s_after_cs)
    else $error("threshold moved inside frame");
  a_oe_off: assert property (s_desel |-> !so_oe)
    else $error("output driven while deselected");
  a_reset_dflt: assert property ($fell(rst) |-> ecc_enable_o && fast_read_enable_o
    && !protect_arm_o && flip_threshold_o == 4'h0)
    else $error("wrong value after reset");
endmodule

// file: dv/fsf_host_model.sv
/* Serial host model: mode 0 command frames, msb first.
   Assumes the core clock runs far faster than the link clock. */
`timescale 1ns/100ps
module fsf_host_model (
  output logic      link_sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_o
);
  // link clock stands low and select high between frames
  initial begin
    link_sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // ****
  // one frame; the last eight sampled bits come back in rx
  // ****
  task automatic xfer(input int nb, input logic [31:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    cs_n = 1'b0;
    #80;
    for (int i = 0; i < nb * 8; i++) begin
      si = tx[31-i];
      #80;
      link_sck = 1'b1;
      rx = {rx[6:0], so_o};
      #80;
      link_sck = 1'b0;
    end
    si = ~si; // no stale level once released
    cs_n = 1'b1;
    #120;
  endtask
endmodule

// file: dv/fsf_feature_table_tb.sv
/* Bench for the feature table, driven through the host model.
   Assumes the checker and host model are compiled before it. */
`timescale 1ns/100ps
module fsf_feature_table_tb;
  logic                    clock = 1'b0;
  logic                    rst = 1'b1;
  logic                    wp_n = 1'b1;
  fsf_pkg::fsf_core_stat_t core_stat = '0;
  fsf_pkg::fsf_cmd_t       cmd_o, last_cmd;
  logic                    link_sck, cs_n, si, so_o, so_oe, abort_o;
  logic [3:0]              cfg_lv, thr;
  logic [7:0]              rx;
  logic [7:0]              da [4] = '{8'hA0, 8'hB0, 8'hC0, 8'h10};
  logic [7:0]              dv [4] = '{8'h38, 8'h16, 8'h00, 8'h00};
  int                      error_cnt = 0;
  int                      samples_checked = 0;
  int                      seed = 82;
  int                      cmd_cnt = 0, abort_cnt = 0, n, r, blk, k;
  fsf_feature_table i_fsf_feature_table (.clock, .rst, .link_sck, .cs_n, .si, .wp_n,
    .so_o, .so_oe, .core_stat, .cmd_o, .abort_o, .protect_arm_o(cfg_lv[3]),
    .id_read_select_o(cfg_lv[2]), .ecc_enable_o(cfg_lv[1]),
    .fast_read_enable_o(cfg_lv[0]), .flip_threshold_o(thr));
  fsf_host_model i_fsf_host_model (.link_sck, .cs_n, .si, .so_o);
  always #5 clock = ~clock;
  // count one-cycle pulses
  always @(posedge clock) begin
    if (cmd_o.valid === 1'b1) begin
      cmd_cnt++;
      last_cmd = cmd_o;
    end
    if (abort_o === 1'b1) begin
      abort_cnt++;
    end
  end
  // ****
  // frame and check helpers
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  // frames start mid-cycle so link edges never meet a core edge
  task automatic x(input int nb, input logic [31:0] tx);
    @(negedge clock);
    i_fsf_host_model.xfer(nb, tx, rx);
  endtask
  task automatic op(input logic [7:0] c);
    x(1, {c, 24'h0});
  endtask
  task automatic rd(input logic [7:0] a);
    x(3, {8'h0F, a, 16'h0});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    x(3, {8'h1F, a, d, 8'h0});
  endtask
  task automatic prog(input logic [7:0] c, input logic [10:0] b);
    x(4, {c, 7'h0, b, 6'h0});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(negedge clock);
    for (k = 0; k < 4; k++) begin
      rd(da[k]);
      chk(rx, dv[k], "default");
    end
    op(8'h06);
    rd(8'hC0);
    chk(rx, 8'h02, "latch set");
    wr(8'hC0, 8'h00);
    rd(8'hC0);
    chk(rx, 8'h02, "latch kept");
    op(8'h04);
    rd(8'hC0);
    chk(rx, 8'h00, "latch clear");
    n = cmd_cnt;
    prog(8'h10, 11'd5);
    op(8'h06);
    prog(8'h2A, 11'd5);
    chk(cmd_cnt, n, "refused");
    $display("test latch done");
    n = $random(seed);
    wr(8'hB0, n[7:0]);
    wr(8'h10, n[15:8]);
    rd(8'hB0);
    chk(rx, (n[7:0] & 8'hD2) | 8'h04, "cfg");
    chk(cfg_lv, {n[7], n[6], n[4], n[1]}, "cfg pins");
    rd(8'h10);
    chk(rx, n[15:8] & 8'hF0, "thr");
    chk(thr, n[15:12], "thr pin");
    wr(8'hB0, 8'h02);
    for (r = 0; r < 8; r++) begin
      blk = {$random(seed)} % 2048;
      wr(8'hA0, 8'(r << 3));
      op(8'h06);
      n = cmd_cnt;
      prog(r[0] ? 8'hD8 : 8'h10, blk[10:0]);
      k = (r == 7 || (r != 0 && blk >= 2048 - (2048 >> (7 - r))));
      chk(cmd_cnt - n, 1, "cmd");
      chk({last_cmd.locked, last_cmd.row}, {k[0], blk[10:0], 6'h0}, "lock");
    end
    wr(8'hA0, 8'hB8);
    @(posedge clock) wp_n <= 1'b0;
    wr(8'hA0, 8'h00);
    rd(8'hA0);
    chk(rx, 8'hB8, "guard");
    @(posedge clock) wp_n <= 1'b1;
    wr(8'hA0, 8'h00);
    rd(8'hA0);
    chk(rx, 8'h00, "unguard");
    $display("test table done");
    for (r = 0; r < 2; r++) begin
      @(posedge clock) core_stat.busy <= 1'b1;
      n = abort_cnt;
      op(r[0] ? 8'hFE : 8'hFF);
      @(posedge clock) core_stat.busy <= 1'b0;
      chk(abort_cnt - n, 1, "abort");
      rd(8'hC0);
      chk(rx[0], 1'b1, "busy");
      for (k = 0; k < 20 && rx[0] !== 1'b0; k++) begin
        rd(8'hC0);
      end
      if (k == 20) begin
        chk(0, 1, "ready");
        test_done;
      end
      rd(8'hB0);
      chk(rx, 8'h06, "kept");
    end
    // erase fail rises during the third byte; the fourth must show it
    fork
      x(4, {8'h0F, 8'hC0, 16'h0});
      begin
        repeat (350) @(posedge clock);
        core_stat.erase_fail <= 1'b1;
      end
    join
    chk(rx, 8'h06, "live");
    $display("test reset done");
    test_done;
  end
endmodule
bind fsf_feature_table fsf_feature_table_checker i_chk (.clock, .rst, .cs_n,
  .so_oe, .core_stat, .cmd_o, .abort_o, .protect_arm_o, .ecc_enable_o,
  .fast_read_enable_o, .flip_threshold_o);
